// ---- hdl/kgc_pkg.sv ----
// Constants and carriers for the keypad GPIO configuration block.
// Assumes a byte-wide register port fed by the serial slave engine.
package kgc_pkg;
    localparam int KGC_PINS = 18;
    localparam logic [7:0] KGC_RESET_VALUE = 8'h00;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] KGC_FIRST_UNLOCK_KEY = 8'h0F;
    localparam logic [7:0] KGC_SECOND_UNLOCK_KEY = 8'h10;
    localparam logic [7:0] KGC_PIN_IRQ_FLAGS_ROWS = 8'h11;
    localparam logic [7:0] KGC_PIN_IRQ_FLAGS_COLS_LOW = 8'h12;
    localparam logic [7:0] KGC_PIN_IRQ_FLAGS_COLS_HIGH = 8'h13;
    localparam logic [7:0] KGC_PIN_LEVEL_ROWS = 8'h14;
    localparam logic [7:0] KGC_PIN_LEVEL_COLS_LOW = 8'h15;
    localparam logic [7:0] KGC_PIN_LEVEL_COLS_HIGH = 8'h16;
    localparam logic [7:0] KGC_OUTPUT_VALUE_ROWS = 8'h17;
    localparam logic [7:0] KGC_OUTPUT_VALUE_COLS_LOW = 8'h18;
    localparam logic [7:0] KGC_OUTPUT_VALUE_COLS_HIGH = 8'h19;
    localparam logic [7:0] KGC_PIN_IRQ_ENABLE_ROWS = 8'h1A;
    localparam logic [7:0] KGC_PIN_IRQ_ENABLE_COLS_LOW = 8'h1B;
    localparam logic [7:0] KGC_PIN_IRQ_ENABLE_COLS_HIGH = 8'h1C;
    localparam logic [7:0] KGC_MATRIX_SELECT_ROWS = 8'h1D;
    localparam logic [7:0] KGC_MATRIX_SELECT_COLS_LOW = 8'h1E;
    localparam logic [7:0] KGC_MATRIX_SELECT_COLS_HIGH = 8'h1F;
    localparam logic [7:0] KGC_FIFO_EVENT_SELECT_ROWS = 8'h20;
    localparam logic [7:0] KGC_FIFO_EVENT_SELECT_COLS_LOW = 8'h21;
    localparam logic [7:0] KGC_FIFO_EVENT_SELECT_COLS_HIGH = 8'h22;
    localparam logic [7:0] KGC_PIN_DIRECTION_ROWS = 8'h23;
    localparam logic [7:0] KGC_PIN_DIRECTION_COLS_LOW = 8'h24;
    localparam logic [7:0] KGC_PIN_DIRECTION_COLS_HIGH = 8'h25;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int KGC_COLS_LOW_BASE = 8;
    localparam int KGC_COLS_HIGH_BASE = 16;
    localparam int KGC_COLS_HIGH_BITS = 2;
    localparam int KGC_UNLOCK_CODE_BITS = 7;
    localparam logic [6:0] KGC_GPI_CODE_BASE = 7'd97;
    localparam logic [6:0] KGC_GPI_CODE_LAST = 7'd114;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kgc_reg_req_s;

    typedef struct packed {
        logic press;
        logic [6:0] code;
    } kgc_event_s;
endpackage

// ---- hdl/kgc_pin_slice.sv ----
// Per-pin change detection, interrupt flags and level latch.
// Assumes pin levels are synchronous to clock_in.
`timescale 1ns/100ps
`default_nettype none
module kgc_pin_slice #(
    parameter int W = 8
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [W-1:0] level_in,
    input wire logic [W-1:0] irq_en_in,
    input wire logic [W-1:0] gpi_in,
    input wire logic flag_rd_in,
    input wire logic level_clr_in,
    output logic [W-1:0] change_out,
    output logic [W-1:0] irq_set_out,
    output logic [W-1:0] flags_out,
    output logic [W-1:0] level_view_out
);
    import kgc_pkg::*;
    logic [W-1:0] prev_reg;
    logic [W-1:0] flags_reg;
    logic [W-1:0] latch_reg;

    assign change_out = level_in ^ prev_reg;
    assign irq_set_out = change_out & irq_en_in & gpi_in; // [R09]
    assign flags_out = flags_reg;
    // Current level plus any high seen since the last double read
    assign level_view_out = latch_reg | level_in; // [R06]

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            prev_reg <= '0;
        end else if (ce_in) begin
            prev_reg <= level_in;
        end
    end

    // A set in the clearing cycle survives the read
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            flags_reg <= '0;
        end else if (ce_in) begin
            flags_reg <= (flag_rd_in ? '0 : flags_reg) | irq_set_out; // [R03] [R05]
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            latch_reg <= '0;
        end else if (ce_in) begin
            latch_reg <= (level_clr_in ? '0 : latch_reg) | level_in; // [R07]
        end
    end
endmodule
`default_nettype wire

// ---- hdl/kgc_gpio_regs.sv ----
// Register file and pin control of the keypad GPIO block.
// Assumes a serial slave engine presents byte reads and writes as
// one-cycle strobes, and a scan engine owns pins in the matrix.
//
// Overview of operation
// [R01] Unlock registers hold two unlock key numbers
// [R02] Either unlock register zero disables keylock
// [R03] Summary interrupt marks each causing pin flag
// [R04] Summary clears only when all flags zero
// [R05] Reading a flag register clears it
// [R06] Level registers show current pin state
// [R07] Second consecutive level read clears latch
// [R08] Output pins follow output value bits
// [R09] Interrupt enables act on general inputs only
// [R10] Enabled input change sets summary interrupt
// [R11] Selection zero means GPIO with direction
// [R12] Selection one hands pin to matrix
// [R13] Rows, low columns, then columns nine:eight
// [R14] Event-mode inputs push events to FIFO
// [R15] Direction zero input, one output
// [R16] Input events use codes 97 to 114
// [R17] Host write-one clears summary when allowed
// [R18] Unlock compare ignores bit seven
// [R19] Matrix pins ignore GPIO control bits
`timescale 1ns/100ps
`default_nettype none
module kgc_gpio_regs (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire kgc_pkg::kgc_reg_req_s req_in,
    output logic [7:0] rdata_out,
    input wire logic [kgc_pkg::KGC_PINS-1:0] pin_in,
    output logic [kgc_pkg::KGC_PINS-1:0] pin_out,
    output logic [kgc_pkg::KGC_PINS-1:0] pin_oe_out,
    output logic [kgc_pkg::KGC_PINS-1:0] matrix_select_out,
    output logic [6:0] first_unlock_code_out,
    output logic [6:0] second_unlock_code_out,
    output logic keylock_allowed_out,
    input wire logic summary_clear_in,
    output logic general_input_irq_summary_out,
    output kgc_pkg::kgc_event_s event_out,
    output logic event_valid_out,
    input wire logic event_ready_in
);
    import kgc_pkg::*;
    localparam int N = KGC_PINS;
    localparam int LB = KGC_COLS_LOW_BASE;
    localparam int HB = KGC_COLS_HIGH_BASE;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] first_unlock_key_reg;
    logic [7:0] second_unlock_key_reg;
    logic [N-1:0] out_val_reg;
    logic [N-1:0] irq_en_reg;
    logic [N-1:0] matrix_reg;
    logic [N-1:0] evt_sel_reg;
    logic [N-1:0] dir_reg;
    logic [N-1:0] general_input_pin;
    logic [N-1:0] gpo;
    logic wr;
    logic rd;

    assign wr = ce_in && req_in.wr;
    assign rd = ce_in && req_in.rd;
    assign general_input_pin = ~matrix_reg & ~dir_reg; // [R11] [R15] [R19]
    assign gpo = ~matrix_reg & dir_reg; // [R12] [R19]

    // Byte lane update of an 18-pin vector
    function automatic logic [N-1:0] put_byte(
        input logic [N-1:0] v,
        input logic [1:0] lane,
        input logic [7:0] d
    );
        logic [N-1:0] r;
        r = v;
        unique case (lane)
            2'd0: r[LB-1:0] = d; // [R13]
            2'd1: r[HB-1:LB] = d;
            default: r[N-1:HB] = d[KGC_COLS_HIGH_BITS-1:0];
        endcase
        return r;
    endfunction

    function automatic logic [7:0] get_byte(
        input logic [N-1:0] v,
        input logic [1:0] lane
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (lane)
            2'd0: r = v[LB-1:0];
            2'd1: r = v[HB-1:LB];
            default: r[KGC_COLS_HIGH_BITS-1:0] = v[N-1:HB];
        endcase
        return r;
    endfunction

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            first_unlock_key_reg <= KGC_RESET_VALUE;
            second_unlock_key_reg <= KGC_RESET_VALUE;
        end else if (wr) begin
            if (req_in.addr == KGC_FIRST_UNLOCK_KEY) begin
                first_unlock_key_reg <= req_in.wdata; // [R01]
            end
            if (req_in.addr == KGC_SECOND_UNLOCK_KEY) begin
                second_unlock_key_reg <= req_in.wdata;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            out_val_reg <= '0;
            irq_en_reg <= '0;
            matrix_reg <= '0;
            evt_sel_reg <= '0;
            dir_reg <= '0;
        end else if (wr) begin
            unique case (req_in.addr)
                KGC_OUTPUT_VALUE_ROWS: out_val_reg <= put_byte(out_val_reg, 2'd0, req_in.wdata);
                KGC_OUTPUT_VALUE_COLS_LOW: out_val_reg <= put_byte(out_val_reg, 2'd1, req_in.wdata);
                KGC_OUTPUT_VALUE_COLS_HIGH: out_val_reg <= put_byte(out_val_reg, 2'd2, req_in.wdata);
                KGC_PIN_IRQ_ENABLE_ROWS: irq_en_reg <= put_byte(irq_en_reg, 2'd0, req_in.wdata);
                KGC_PIN_IRQ_ENABLE_COLS_LOW: irq_en_reg <= put_byte(irq_en_reg, 2'd1, req_in.wdata);
                KGC_PIN_IRQ_ENABLE_COLS_HIGH: irq_en_reg <= put_byte(irq_en_reg, 2'd2, req_in.wdata);
                KGC_MATRIX_SELECT_ROWS: matrix_reg <= put_byte(matrix_reg, 2'd0, req_in.wdata);
                KGC_MATRIX_SELECT_COLS_LOW: matrix_reg <= put_byte(matrix_reg, 2'd1, req_in.wdata);
                KGC_MATRIX_SELECT_COLS_HIGH: matrix_reg <= put_byte(matrix_reg, 2'd2, req_in.wdata);
                KGC_FIFO_EVENT_SELECT_ROWS: evt_sel_reg <= put_byte(evt_sel_reg, 2'd0, req_in.wdata);
                KGC_FIFO_EVENT_SELECT_COLS_LOW: evt_sel_reg <= put_byte(evt_sel_reg, 2'd1, req_in.wdata);
                KGC_FIFO_EVENT_SELECT_COLS_HIGH: evt_sel_reg <= put_byte(evt_sel_reg, 2'd2, req_in.wdata);
                KGC_PIN_DIRECTION_ROWS: dir_reg <= put_byte(dir_reg, 2'd0, req_in.wdata);
                KGC_PIN_DIRECTION_COLS_LOW: dir_reg <= put_byte(dir_reg, 2'd1, req_in.wdata);
                KGC_PIN_DIRECTION_COLS_HIGH: dir_reg <= put_byte(dir_reg, 2'd2, req_in.wdata);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Double-read tracking for the level registers
    // ------------------------------------------------------------
    logic [7:0] last_addr_reg;
    logic armed_reg;
    logic lvl_hit;
    logic second_rd;

    assign lvl_hit = req_in.addr >= KGC_PIN_LEVEL_ROWS && req_in.addr <= KGC_PIN_LEVEL_COLS_HIGH;
    assign second_rd = rd && lvl_hit && armed_reg && last_addr_reg == req_in.addr;

    // Any other access in between breaks the pair
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            armed_reg <= 1'b0;
            last_addr_reg <= KGC_RESET_VALUE;
        end else if (rd || wr) begin
            armed_reg <= rd && lvl_hit && !second_rd; // [R07]
            last_addr_reg <= req_in.addr;
        end
    end

    // ------------------------------------------------------------
    // Pin slices: rows, low columns, high columns
    // ------------------------------------------------------------
    logic [N-1:0] change;
    logic [N-1:0] irq_set;
    logic [N-1:0] flags;
    logic [N-1:0] level_view;

    kgc_pin_slice #(.W(LB)) u_rows (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .level_in(pin_in[LB-1:0]),
        .irq_en_in(irq_en_reg[LB-1:0]),
        .gpi_in(general_input_pin[LB-1:0]),
        .flag_rd_in(rd && req_in.addr == KGC_PIN_IRQ_FLAGS_ROWS),
        .level_clr_in(second_rd && req_in.addr == KGC_PIN_LEVEL_ROWS),
        .change_out(change[LB-1:0]),
        .irq_set_out(irq_set[LB-1:0]),
        .flags_out(flags[LB-1:0]),
        .level_view_out(level_view[LB-1:0])
    );

    kgc_pin_slice #(.W(HB-LB)) u_cols_low (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .level_in(pin_in[HB-1:LB]),
        .irq_en_in(irq_en_reg[HB-1:LB]),
        .gpi_in(general_input_pin[HB-1:LB]),
        .flag_rd_in(rd && req_in.addr == KGC_PIN_IRQ_FLAGS_COLS_LOW),
        .level_clr_in(second_rd && req_in.addr == KGC_PIN_LEVEL_COLS_LOW),
        .change_out(change[HB-1:LB]),
        .irq_set_out(irq_set[HB-1:LB]),
        .flags_out(flags[HB-1:LB]),
        .level_view_out(level_view[HB-1:LB])
    );

    kgc_pin_slice #(.W(KGC_COLS_HIGH_BITS)) u_cols_high (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .level_in(pin_in[N-1:HB]),
        .irq_en_in(irq_en_reg[N-1:HB]),
        .gpi_in(general_input_pin[N-1:HB]),
        .flag_rd_in(rd && req_in.addr == KGC_PIN_IRQ_FLAGS_COLS_HIGH),
        .level_clr_in(second_rd && req_in.addr == KGC_PIN_LEVEL_COLS_HIGH),
        .change_out(change[N-1:HB]),
        .irq_set_out(irq_set[N-1:HB]),
        .flags_out(flags[N-1:HB]),
        .level_view_out(level_view[N-1:HB])
    );

    // ------------------------------------------------------------
    // Summary interrupt bit
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            general_input_irq_summary_out <= 1'b0;
        end else if (ce_in) begin
            if (|irq_set) begin
                general_input_irq_summary_out <= 1'b1; // [R10]
            end else if (summary_clear_in && flags == '0) begin
                general_input_irq_summary_out <= 1'b0; // [R04] [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rdata_out <= KGC_RESET_VALUE;
        end else if (rd) begin
            unique case (req_in.addr)
                KGC_FIRST_UNLOCK_KEY: rdata_out <= first_unlock_key_reg;
                KGC_SECOND_UNLOCK_KEY: rdata_out <= second_unlock_key_reg;
                KGC_PIN_IRQ_FLAGS_ROWS: rdata_out <= get_byte(flags, 2'd0);
                KGC_PIN_IRQ_FLAGS_COLS_LOW: rdata_out <= get_byte(flags, 2'd1);
                KGC_PIN_IRQ_FLAGS_COLS_HIGH: rdata_out <= get_byte(flags, 2'd2);
                KGC_PIN_LEVEL_ROWS: rdata_out <= get_byte(level_view, 2'd0);
                KGC_PIN_LEVEL_COLS_LOW: rdata_out <= get_byte(level_view, 2'd1);
                KGC_PIN_LEVEL_COLS_HIGH: rdata_out <= get_byte(level_view, 2'd2);
                KGC_OUTPUT_VALUE_ROWS: rdata_out <= get_byte(out_val_reg, 2'd0);
                KGC_OUTPUT_VALUE_COLS_LOW: rdata_out <= get_byte(out_val_reg, 2'd1);
                KGC_OUTPUT_VALUE_COLS_HIGH: rdata_out <= get_byte(out_val_reg, 2'd2);
                KGC_PIN_IRQ_ENABLE_ROWS: rdata_out <= get_byte(irq_en_reg, 2'd0);
                KGC_PIN_IRQ_ENABLE_COLS_LOW: rdata_out <= get_byte(irq_en_reg, 2'd1);
                KGC_PIN_IRQ_ENABLE_COLS_HIGH: rdata_out <= get_byte(irq_en_reg, 2'd2);
                KGC_MATRIX_SELECT_ROWS: rdata_out <= get_byte(matrix_reg, 2'd0);
                KGC_MATRIX_SELECT_COLS_LOW: rdata_out <= get_byte(matrix_reg, 2'd1);
                KGC_MATRIX_SELECT_COLS_HIGH: rdata_out <= get_byte(matrix_reg, 2'd2);
                KGC_FIFO_EVENT_SELECT_ROWS: rdata_out <= get_byte(evt_sel_reg, 2'd0);
                KGC_FIFO_EVENT_SELECT_COLS_LOW: rdata_out <= get_byte(evt_sel_reg, 2'd1);
                KGC_FIFO_EVENT_SELECT_COLS_HIGH: rdata_out <= get_byte(evt_sel_reg, 2'd2);
                KGC_PIN_DIRECTION_ROWS: rdata_out <= get_byte(dir_reg, 2'd0);
                KGC_PIN_DIRECTION_COLS_LOW: rdata_out <= get_byte(dir_reg, 2'd1);
                KGC_PIN_DIRECTION_COLS_HIGH: rdata_out <= get_byte(dir_reg, 2'd2);
                default: rdata_out <= KGC_RESET_VALUE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive and matrix hand-over
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pin_out <= '0;
            pin_oe_out <= '0;
            matrix_select_out <= '0;
        end else if (ce_in) begin
            pin_out <= out_val_reg & gpo; // [R08]
            pin_oe_out <= gpo; // [R15] [R19]
            matrix_select_out <= matrix_reg; // [R12]
        end
    end

    // ------------------------------------------------------------
    // Unlock codes for the keylock engine
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            first_unlock_code_out <= '0;
            second_unlock_code_out <= '0;
            keylock_allowed_out <= 1'b0;
        end else if (ce_in) begin
            first_unlock_code_out <= first_unlock_key_reg[KGC_UNLOCK_CODE_BITS-1:0]; // [R18]
            second_unlock_code_out <= second_unlock_key_reg[KGC_UNLOCK_CODE_BITS-1:0];
            keylock_allowed_out <= first_unlock_key_reg != 8'h00 && second_unlock_key_reg != 8'h00; // [R02]
        end
    end

    // ------------------------------------------------------------
    // Event queueing toward the key event FIFO
    // ------------------------------------------------------------
    // Pending bits hold back-pressured events; a second change of
    // the same pin before service keeps only its latest direction.
    logic [N-1:0] pend_reg;
    logic [N-1:0] press_reg;
    logic [N-1:0] new_evt;
    logic [N-1:0] pick;
    logic [4:0] pick_idx;
    logic take;

    assign new_evt = change & evt_sel_reg & general_input_pin; // [R14]
    assign take = !event_valid_out || event_ready_in;

    always_comb begin
        pick = '0;
        pick_idx = 5'd0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                pick_idx = 5'(i);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pend_reg <= '0;
            press_reg <= '0;
        end else if (ce_in) begin
            pend_reg <= (take ? pend_reg & ~pick : pend_reg) | new_evt;
            press_reg <= (press_reg & ~new_evt) | (new_evt & ~pin_in);
        end
    end

    // A low level counts as a press, matching pulled-up inputs
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            event_valid_out <= 1'b0;
            event_out <= '0;
        end else if (ce_in && take) begin
            event_valid_out <= |pend_reg;
            event_out.press <= |(press_reg & pick);
            event_out.code <= KGC_GPI_CODE_BASE + 7'(pick_idx); // [R16]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_lock_zero: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R02]
        ce_in && first_unlock_key_reg == 8'h00 |=> !keylock_allowed_out)
        else $error("keylock allowed with zero unlock key");
    chk_flag_clear: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R05]
        rd && req_in.addr == KGC_PIN_IRQ_FLAGS_ROWS && irq_set[LB-1:0] == '0
        |=> flags[LB-1:0] == '0)
        else $error("flag register not cleared by read");
    chk_summary_hold: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R04]
        ce_in && general_input_irq_summary_out && flags != '0 |=> general_input_irq_summary_out)
        else $error("summary cleared with flags pending");
    chk_summary_set: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R10]
        ce_in && |irq_set |=> general_input_irq_summary_out && (flags & $past(irq_set)) == $past(irq_set))
        else $error("enabled change did not set summary and flag");
    chk_drive_value: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R08]
        ce_in |=> pin_out == ($past(out_val_reg) & $past(gpo)))
        else $error("output pin value wrong");
    chk_matrix_free: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R19]
        ce_in |=> (pin_oe_out & $past(matrix_reg)) == '0)
        else $error("matrix pin driven by GPIO");
    chk_irq_gated: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R09]
        ce_in && flags == '0 && (change & irq_en_reg & general_input_pin) == '0 |=> flags == '0)
        else $error("flag set without enabled input change");
    chk_code_range: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R16]
        event_valid_out |-> event_out.code >= KGC_GPI_CODE_BASE && event_out.code <= KGC_GPI_CODE_LAST)
        else $error("event code out of range");
    chk_level_pair: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R07]
        rd && req_in.addr == KGC_PIN_LEVEL_ROWS && !armed_reg |=> armed_reg)
        else $error("first level read did not arm clear");
    chk_evt_hold: assert property (@(posedge clock_in) disable iff (!rstn_in) // [R14]
        event_valid_out && !event_ready_in |=> event_valid_out && $stable(event_out))
        else $error("event dropped under back-pressure");

    cov_summary: cover property (@(posedge clock_in) disable iff (!rstn_in)
        general_input_irq_summary_out ##1 !general_input_irq_summary_out);
    cov_event: cover property (@(posedge clock_in) disable iff (!rstn_in)
        event_valid_out && event_ready_in);
    cov_double: cover property (@(posedge clock_in) disable iff (!rstn_in)
        second_rd);
endmodule
`default_nettype wire

// ---- bench/kgc_pin_world.sv ----
// Pin environment and event sink at the far side of the block.
// Assumes undriven pins rest at the levels the bench sets.
`timescale 1ns/100ps
`default_nettype none
module kgc_pin_world (
    input wire logic clock_in,
    input wire logic [17:0] drive_in,
    input wire logic [17:0] oe_in,
    input wire logic [17:0] ext_in,
    input wire logic stall_in,
    output logic [17:0] level_out,
    output logic ready_out
);
    // A driven pin reads back its own drive value
    assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
    initial ready_out = 1'b0;
    always @(posedge clock_in) begin
        ready_out <= ~stall_in;
    end
endmodule
`default_nettype wire

// ---- bench/kgc_gpio_regs_bench.sv ----
// Bench for the keypad GPIO register block.
// Assumes the block and the pin model share one clock.
`timescale 1ns/100ps
`default_nettype none
module kgc_gpio_regs_bench;
    import kgc_pkg::*;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    kgc_reg_req_s req = '0;
    logic clr = 1'b0;
    logic ce = 1'b1;
    logic stall = 1'b1;
    logic [17:0] ext = 18'h3FFFF;
    logic [7:0] rdata;
    logic [17:0] pin_in, pin_out, pin_oe, msel;
    logic [6:0] uk1, uk2;
    logic lock_ok, summary, ev_valid, ev_ready, taken;
    kgc_event_s ev;
    int errors = 0;
    int n_compared = 0;
    int i;
    kgc_gpio_regs u_kgc_gpio_regs (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce), .req_in(req),
        .rdata_out(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe), .matrix_select_out(msel),
        .first_unlock_code_out(uk1), .second_unlock_code_out(uk2), .keylock_allowed_out(lock_ok),
        .summary_clear_in(clr), .general_input_irq_summary_out(summary), .event_out(ev),
        .event_valid_out(ev_valid), .event_ready_in(ev_ready));
    kgc_pin_world u_kgc_pin_world (.clock_in(clock_in), .drive_in(pin_out), .oe_in(pin_oe), .ext_in(ext),
        .stall_in(stall), .level_out(pin_in), .ready_out(ev_ready));
    always_comb taken = ev_valid & ev_ready;
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step(1);
        req = '0;
        step(2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        step(1);
        req = '0;
        chk($sformatf("register %h", a), {10'h000, exp}, {10'h000, rdata});
        step(1);
    endtask
    task automatic clear_summary;
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_high(input string what, input bit want_taken);
        logic s;
        s = want_taken ? taken : summary;
        for (i = 0; i < 20 && s !== 1'b1; i++) begin
            step(1);
            s = want_taken ? taken : summary;
        end
        chk(what, 18'h1, {17'h0, s});
        if (s !== 1'b1) tally_and_finish();
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(4);
        rstn_in = 1'b1;
        rd(8'h23, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset done");
        wr(8'h0F, 8'h85);
        chk("first code", 18'h05, {11'h0, uk1});
        chk("lock allowed", 18'h0, {17'h0, lock_ok});
        wr(8'h10, 8'h12);
        chk("second code", 18'h12, {11'h0, uk2});
        chk("lock allowed", 18'h1, {17'h0, lock_ok});
        $display("test unlock done");
        wr(8'h23, 8'h0F);
        wr(8'h17, 8'hA5);
        chk("pin drive", 18'h0000F, pin_oe);
        chk("pin value", 18'h00005, pin_out);
        rd(8'h14, 8'hFF);
        ext[7:4] = 4'h0;
        step(2);
        rd(8'h14, 8'hFF);
        rd(8'h14, 8'h05);
        wr(8'h1D, 8'h01);
        chk("matrix pins", 18'h00001, msel);
        chk("pin drive", 18'h0000E, pin_oe);
        // A write while the clock enable is low must not land
        ce = 1'b0;
        wr(8'h17, 8'hFF);
        ce = 1'b1;
        rd(8'h17, 8'hA5);
        $display("test pins done");
        wr(8'h1C, 8'h01);
        ext[16] = 1'b0;
        wait_high("irq summary", 1'b0);
        clear_summary();
        chk("irq summary", 18'h1, {17'h0, summary});
        rd(8'h13, 8'h01);
        rd(8'h13, 8'h00);
        clear_summary();
        chk("irq summary", 18'h0, {17'h0, summary});
        $display("test irq done");
        wr(8'h21, 8'h01);
        ext[8] = 1'b0;
        step(4);
        chk("event valid", 18'h1, {17'h0, ev_valid});
        stall = 1'b0;
        wait_high("event taken", 1'b1);
        chk("event", 18'h000E9, {10'h0, ev});
        // Release of the same pin, held by back-pressure
        stall = 1'b1;
        ext[8] = 1'b1;
        step(4);
        chk("event release", 18'h00169, {9'h0, ev_valid, ev});
        $display("test event done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
